// ---- include/ppc_pkg.sv ----
package ppc_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PINS    = 4'h8;

  // control register fields
  localparam int unsigned BIT_RDEN  = 8;
  localparam int unsigned BIT_CSF_H = 7;
  localparam int unsigned BIT_CSF_L = 6;
  localparam int unsigned BIT_ALP   = 5;
  localparam int unsigned BIT_CHIP_SELECT_TWO_POLARITY  = 4;
  localparam int unsigned BIT_BEP   = 2;
  localparam int unsigned BIT_WRITE_STROBE_POLARITY  = 1;
  localparam int unsigned BIT_READ_STROBE_POLARITY  = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // writable bits of the control register; the rest read as zero
  localparam logic [15:0] CTRL_MASK  = 16'h01f7;

  // mode register field
  localparam int unsigned BIT_MODE_H = 1;
  localparam int unsigned BIT_MODE_L = 0;
  localparam logic [1:0]  MODE_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPC_CSF_ADDR   = 2'h0,
    PPC_CSF_CS2    = 2'h1,
    PPC_CSF_BOTH   = 2'h2,
    PPC_CSF_RESVD  = 2'h3
  } ppc_csf_e;

  typedef enum logic [1:0] {
    PPC_MODE_SLAVE_A = 2'h0,
    PPC_MODE_SLAVE_B = 2'h1,
    PPC_MODE_MASTER2 = 2'h2,
    PPC_MODE_MASTER1 = 2'h3
  } ppc_mode_e;

  // raw, active-high strobes from the transfer engine
  typedef struct packed {
    logic read;
    logic write;
    logic enable;
    logic rw_dir;
    logic latch_low;
    logic latch_high;
    logic cs1;
    logic cs2;
    logic byte_en;
    logic addr_a14;
    logic addr_a15;
  } ppc_raw_s;

  // pin levels and enables
  typedef struct packed {
    logic read_strobe_pin;
    logic write_strobe_pin;
    logic read_strobe_oe;
    logic write_strobe_oe;
    logic address_latch_low;
    logic address_latch_high;
    logic chip_select_one_pin;
    logic chip_select_two_pin;
    logic byte_enable_pin;
  } ppc_pins_s;

endpackage

// ---- hw/ppc_pin_map.sv ----
module ppc_pin_map
  import ppc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [15:0] ctrl,
  input  wire logic [1:0] port_mode_field,
  input  wire ppc_raw_s   raw,
  output ppc_pins_s       pins
);

  ppc_pins_s nxt_pins;
  ppc_pins_s pins_ff;

  function automatic logic pol(input logic lvl, input logic act_high);
    pol = act_high ? lvl : ~lvl;
  endfunction

  always_comb begin
    logic     master1;
    ppc_csf_e csf;
    master1 = 1'b0;
    csf = PPC_CSF_ADDR;
    nxt_pins = '0;
    master1 = (port_mode_field == PPC_MODE_MASTER1);
    csf = ppc_csf_e'(ctrl[BIT_CSF_H:BIT_CSF_L]);
    // master 1: write pin carries enable, read pin carries direction
    if (master1) begin
      nxt_pins.write_strobe_pin = pol(raw.enable, ctrl[BIT_WRITE_STROBE_POLARITY]);
      nxt_pins.read_strobe_pin  = pol(raw.rw_dir, ctrl[BIT_READ_STROBE_POLARITY]);
    end else begin
      nxt_pins.write_strobe_pin = pol(raw.write, ctrl[BIT_WRITE_STROBE_POLARITY]);
      nxt_pins.read_strobe_pin  = pol(raw.read, ctrl[BIT_READ_STROBE_POLARITY]);
    end
    nxt_pins.read_strobe_oe  = ctrl[BIT_RDEN];
    nxt_pins.write_strobe_oe = ctrl[BIT_RDEN];
    nxt_pins.address_latch_low  = pol(raw.latch_low, ctrl[BIT_ALP]);
    nxt_pins.address_latch_high = pol(raw.latch_high, ctrl[BIT_ALP]);
    nxt_pins.byte_enable_pin    = pol(raw.byte_en, ctrl[BIT_BEP]);
    case (csf)
      PPC_CSF_BOTH: begin
        // cs1 polarity lives outside this block; driven active-high
        nxt_pins.chip_select_one_pin = raw.cs1;
        nxt_pins.chip_select_two_pin = pol(raw.cs2, ctrl[BIT_CHIP_SELECT_TWO_POLARITY]);
      end
      PPC_CSF_CS2: begin
        nxt_pins.chip_select_one_pin = raw.addr_a14;
        nxt_pins.chip_select_two_pin = pol(raw.cs2, ctrl[BIT_CHIP_SELECT_TWO_POLARITY]);
      end
      PPC_CSF_ADDR: begin
        nxt_pins.chip_select_one_pin = raw.addr_a14;
        nxt_pins.chip_select_two_pin = raw.addr_a15;
      end
      default: begin
        // reserved code: treat both pins as address lines
        nxt_pins.chip_select_one_pin = raw.addr_a14;
        nxt_pins.chip_select_two_pin = raw.addr_a15;
      end
    endcase
    // pins not used by the port stay low
    if (!ctrl[BIT_RDEN]) begin
      nxt_pins.read_strobe_pin  = 1'b0;
      nxt_pins.write_strobe_pin = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_ff <= '0;
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  assign pins = pins_ff;

endmodule

// ---- hw/ppc_top.sv ----
// Overview of operation
// - Strobe-port enable bit drives read and write strobe pins; cleared leaves them unused.
// - Chip-select function: 10 both selects, 01 second only, 00 both address.
// - Latch polarity bit sets active level of both address latch strobes.
// - Chip select two polarity bit: set active-high, cleared active-low.
// - Byte enable polarity bit: set active-high, cleared active-low.
// - Outside master mode one, write polarity sets write strobe level.
// - In master mode one, write polarity sets enable strobe level.
// - Outside master mode one, read polarity sets read strobe level.
// - In master mode one, read polarity sets read/write direction strobe level.
// - Pins on address-line duty ignore their polarity bits.
//
// Our own choices: the address map and the AXI4-Lite slave port.
module ppc_top
  import ppc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire ppc_raw_s          raw_strobes,
  output ppc_pins_s              pins,
  output logic [1:0]             port_mode_field
);

  logic [15:0]       ctrl_ff;
  logic [1:0]        mode_ff;
  logic              aw_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic              w_held_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0]        rresp_ff;
  logic              do_write;
  logic [DATA_W-1:0] nxt_rdata;
  logic              nxt_rhit;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [DATA_W-1:0] d,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0]  = d[7:0];
    if (strb[1]) merge16[15:8] = d[15:8];
  endfunction

  // address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (do_write && aw_addr_ff == OFS_CONTROL) begin
      ctrl_ff <= merge16(ctrl_ff, w_data_ff, w_strb_ff) & CTRL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= MODE_RESET;
    end else if (do_write && aw_addr_ff == OFS_MODE && w_strb_ff[0]) begin
      mode_ff <= w_data_ff[BIT_MODE_H:BIT_MODE_L];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      // pin status is read-only; unmapped or read-only targets answer slverr
      bresp_ff  <= (aw_addr_ff == OFS_CONTROL || aw_addr_ff == OFS_MODE) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  always_comb begin
    nxt_rdata = '0;
    nxt_rhit  = 1'b1;
    case (s_axi_araddr)
      OFS_CONTROL: nxt_rdata[15:0] = ctrl_ff;
      OFS_MODE:    nxt_rdata[1:0]  = mode_ff;
      OFS_PINS:    nxt_rdata[8:0]  = pins;
      default:     nxt_rhit        = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rhit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
  assign port_mode_field = mode_ff;

  // pin polarity and function steering
  ppc_pin_map u_pin_map (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .ctrl            (ctrl_ff),
    .port_mode_field (mode_ff),
    .raw             (raw_strobes),
    .pins            (pins)
  );

endmodule

// ---- tb/ppc_monitor.sv ----
package ppc_tbx_pkg;
  import ppc_pkg::*;
  function automatic ppc_pins_s ppc_exp(ppc_raw_s r, logic [15:0] c, logic [1:0] m);
    ppc_pins_s p;
    logic      m1;
    m1 = m == 2'h3;
    p.read_strobe_oe = c[BIT_RDEN];
    p.write_strobe_oe = c[BIT_RDEN];
    p.read_strobe_pin = c[BIT_RDEN] & ((m1 ? r.rw_dir : r.read) ~^ c[BIT_READ_STROBE_POLARITY]);
    p.write_strobe_pin = c[BIT_RDEN] & ((m1 ? r.enable : r.write) ~^ c[BIT_WRITE_STROBE_POLARITY]);
    p.address_latch_low = r.latch_low ~^ c[BIT_ALP];
    p.address_latch_high = r.latch_high ~^ c[BIT_ALP];
    // reserved code falls back to address duty
    p.chip_select_one_pin = (c[7:6] == 2'h2) ? r.cs1 : r.addr_a14;
    p.chip_select_two_pin = c[7:6] inside {2'h1, 2'h2} ? r.cs2 ~^ c[BIT_CHIP_SELECT_TWO_POLARITY] : r.addr_a15;
    p.byte_enable_pin = r.byte_en ~^ c[BIT_BEP];
    return p;
  endfunction
endpackage

module ppc_monitor
  import ppc_pkg::*, ppc_tbx_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire ppc_raw_s          raw_strobes,
  input wire ppc_pins_s         pins,
  input wire logic [1:0]        port_mode_field
);
  logic        up_ff;
  logic [15:0] ctl_a_ff;
  logic [15:0] ctl_b_ff;
  ppc_pins_s   q_ff;
  always_ff @(posedge aclk) begin
    up_ff <= aresetn;
    q_ff <= ppc_exp(raw_strobes, ctl_b_ff, port_mode_field);
  end
  // shadow lags one cycle to match the register; assumes aw and w are taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_a_ff <= 16'h0000;
      ctl_b_ff <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == OFS_CONTROL) begin
        ctl_a_ff <= s_axi_wdata[15:0] & CTRL_MASK;
      end
      ctl_b_ff <= ctl_a_ff;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answered;
    ##2 s_axi_bvalid;
  endsequence
  property p_bresp; s_wr_taken |-> s_wr_answered; endproperty
  property p_oe; up_ff |-> pins.read_strobe_oe == q_ff.read_strobe_oe && pins.write_strobe_oe == q_ff.write_strobe_oe;
  endproperty
  property p_off; !pins.read_strobe_oe |-> !pins.read_strobe_pin && !pins.write_strobe_pin; endproperty
  property p_cs1; up_ff |-> pins.chip_select_one_pin == q_ff.chip_select_one_pin; endproperty
  property p_cs2; up_ff |-> pins.chip_select_two_pin == q_ff.chip_select_two_pin; endproperty
  property p_latch; up_ff |-> pins[4:3] == q_ff[4:3]; endproperty
  property p_be; up_ff |-> pins.byte_enable_pin == q_ff.byte_enable_pin; endproperty
  property p_wr; up_ff |-> pins.write_strobe_pin == q_ff.write_strobe_pin; endproperty
  property p_rd; up_ff |-> pins.read_strobe_pin == q_ff.read_strobe_pin; endproperty
  a_bresp: assert property (p_bresp) else $error("write answer not on time");
  a_oe: assert property (p_oe) else $error("strobe enable wrong");
  a_off: assert property (p_off) else $error("disabled strobe driven");
  a_cs1: assert property (p_cs1) else $error("select one wrong");
  a_cs2: assert property (p_cs2) else $error("select two wrong");
  a_latch: assert property (p_latch) else $error("latch level wrong");
  a_be: assert property (p_be) else $error("byte enable wrong");
  a_wr: assert property (p_wr) else $error("write strobe wrong");
  a_rd: assert property (p_rd) else $error("read strobe wrong");
endmodule

bind ppc_top ppc_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .raw_strobes(raw_strobes), .pins(pins), .port_mode_field(port_mode_field));

// ---- tb/ppc_far_side.sv ----
module ppc_far_side
  import ppc_pkg::*;
(
  input  wire ppc_pins_s pins,
  input  wire logic      cs2_pol,
  output logic           selected
);
  // peripheral decodes its select at the level it was built for
  assign selected = pins.chip_select_two_pin ~^ cs2_pol;
endmodule

// ---- tb/ppc_bench.sv ----
module ppc_bench
  import ppc_pkg::*, ppc_tbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sel;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h00013ec4;
  logic [1:0]  bresp, rresp, pmode, mode = 2'h0;
  logic [15:0] ctl = 16'h0000;
  ppc_raw_s    raw = 11'h000;
  ppc_pins_s   pins;
  int          fails = 0, samples_checked = 0;

  ppc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .raw_strobes(raw), .pins(pins),
    .port_mode_field(pmode));
  ppc_far_side peer (.pins(pins), .cs2_pol(1'b0), .selected(sel));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp_word(logic [31:0] g, logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic cmp_pins(ppc_pins_s g, ppc_pins_s x);
    cmp_word(32'(g), 32'(x));
  endtask

  // ready is sampled 1 ns after the edge, where it stays until the next edge
  task automatic wr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
    logic at, wt, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      #1;
      at = awvalid & awready;
      wt = wvalid & wready;
      done = bvalid;
      r = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end
  endtask

  task automatic rd(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      #1;
      t = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
    end
  endtask

  task automatic step_pins(int n);
    repeat (n) begin
      lfsr = nxt(lfsr);
      raw <= lfsr[10:0];
      @(posedge aclk);
      #1;
      cmp_pins(pins, ppc_exp(raw, ctl, mode));
      @(posedge aclk);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    print_verdict;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CONTROL, d, r);
    cmp_word(d, 32'h0);
    rd(OFS_MODE, d, r);
    cmp_word(d, 32'h0);
    step_pins(4);
    $display("test reset done");
    // every cs function against every mode, other bits random
    for (int i = 0; i < 64; i++) begin
      lfsr = nxt(lfsr);
      d = {lfsr[31:8], i[3:2], lfsr[5:0]};
      ctl = d[15:0] & CTRL_MASK;
      mode = i[1:0];
      wr(OFS_CONTROL, d, r);
      cmp_word(32'(r), 32'(RESP_OKAY));
      wr(OFS_MODE, {lfsr[29:0], mode}, r);
      cmp_word(32'(r), 32'(RESP_OKAY));
      rd(OFS_CONTROL, d, r);
      cmp_word(d, 32'(ctl));
      cmp_word(32'(r), 32'(RESP_OKAY));
      cmp_word(32'(pmode), 32'(mode));
      step_pins(4);
    end
    $display("test sweep done");
    wr(OFS_PINS, 32'hffffffff, r);
    cmp_word(32'(r), 32'(RESP_SLVERR));
    rd(4'hc, d, r);
    cmp_word(32'(r), 32'(RESP_SLVERR));
    ctl = 16'h0080;
    wr(OFS_CONTROL, 32'h00000080, r);
    raw <= 11'h008;
    @(posedge aclk);
    #1;
    cmp_word(32'(sel), 32'h1);
    // pin status word must mirror the registered pins, upper bits zero
    rd(OFS_PINS, d, r);
    cmp_word(d, 32'(ppc_exp(raw, ctl, mode)));
    cmp_word(32'(r), 32'(RESP_OKAY));
    $display("test corner done");
    print_verdict;
  end
endmodule
